// [rtl/ums_core.sv]
// Modem status, baud divisor, Xon/Xoff match and interrupt logic.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// RULE_01: CTS change sets bit 0, write-1 clears.
// RULE_02: DSR change sets bit 1, write-1 clears.
// RULE_03: Ring rising edge sets bit 2; the code sets it when ring ends (ring_n goes high).
// RULE_04: Carrier change sets bit 3, write-1 clears.
// RULE_05: Loopback bit 4 shows DTR control.
// RULE_06: Loopback bit 5 shows RTS control.
// RULE_07: Loopback bit 6 shows ring control.
// RULE_08: Loopback bit 7 shows carrier control.
// RULE_09: Otherwise bits 7-4 show inverted inputs.
// RULE_10: Divisor 16 bits, resets to 0008h.
// RULE_11: Baud clock is master divided by 6.5.
// RULE_12: Bit time is sixteen times divisor.
// RULE_13: Xon match raises enabled interrupt.
// RULE_14: Xoff match pauses DMA, enabled interrupt.
// RULE_15: Xon transmit sends resume register byte.
// RULE_16: Xoff transmit sends pause register byte.
// RULE_17: Match registers read/write, reset zero.
// RULE_18: Xon match after pause resumes DMA.
// RULE_19: Modem interrupt while change flag set.
module ums_core
    import ums_pkg::*;
(
    input wire logic sys_clk,
    input wire logic master_clk_tick,
    input wire logic reset_n,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire ums_modem_in_t modem_in,
    input wire ums_rx_byte_t rx_byte,
    output logic [7:0] resume_char,
    output logic [7:0] pause_char,
    output logic dma_paused,
    output logic baud_x16_tick,
    output logic bit_tick,
    output logic irq
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Three stages; a change counts once stages two and three agree.
    logic [3:0] s1_r, s2_r, s3_r, stable_r;
    logic [3:0] pin_now;
    logic [3:0] agree;
    assign pin_now = {modem_in.cd_n, modem_in.ring_n, modem_in.dsr_n, modem_in.cts_n};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            assign agree[g] = (s2_r[g] == s3_r[g]);
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    s1_r[g] <= 1'b1;
                    s2_r[g] <= 1'b1;
                    s3_r[g] <= 1'b1;
                    stable_r[g] <= 1'b1;
                end else begin
                    s1_r[g] <= pin_now[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (agree[g]) begin
                        stable_r[g] <= s3_r[g];
                    end
                end
            end
        end
    endgenerate

    logic [3:0] pin_chg;
    assign pin_chg = agree & (s3_r ^ stable_r);

    // ************************************************************
    // Register decode
    // ************************************************************
    logic hit_status, hit_div_lo, hit_div_hi, hit_xon, hit_xoff, hit_ctl, hit_ist, hit_icl, hit_ien;
    assign hit_status = (reg_addr == UMS_ADDR_MODEM_LINE_STATUS);
    assign hit_div_lo = (reg_addr == UMS_ADDR_BAUD_DIVISOR_LOW);
    assign hit_div_hi = (reg_addr == UMS_ADDR_BAUD_DIVISOR_HIGH);
    assign hit_xon = (reg_addr == UMS_ADDR_RESUME_CHAR_MATCH);
    assign hit_xoff = (reg_addr == UMS_ADDR_PAUSE_CHAR_MATCH);
    assign hit_ctl = (reg_addr == UMS_ADDR_MODEM_LINE_CONTROL);
    assign hit_ist = (reg_addr == UMS_ADDR_IRQ_STATUS);
    assign hit_icl = (reg_addr == UMS_ADDR_IRQ_CLEAR);
    assign hit_ien = (reg_addr == UMS_ADDR_IRQ_ENABLE);

    logic [7:0] div_low_r, div_high_r, xon_r, xoff_r, ctl_r;
    logic [UMS_IRQ_W-1:0] irq_en_r, irq_st_r;
    logic [3:0] chg_r;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            div_low_r <= UMS_DIV_LOW_RST; // [RULE_10]
            div_high_r <= UMS_DIV_HIGH_RST; // [RULE_10]
            xon_r <= UMS_CHAR_RST; // [RULE_17]
            xoff_r <= UMS_CHAR_RST; // [RULE_17]
            ctl_r <= UMS_BYTE_ZERO;
            irq_en_r <= '0;
        end else if (reg_wr) begin
            if (hit_div_lo) begin
                div_low_r <= reg_wdata;
            end
            if (hit_div_hi) begin
                div_high_r <= reg_wdata;
            end
            if (hit_xon) begin
                xon_r <= reg_wdata; // [RULE_17]
            end
            if (hit_xoff) begin
                xoff_r <= reg_wdata; // [RULE_17]
            end
            if (hit_ctl) begin
                ctl_r <= reg_wdata;
            end
            if (hit_ien) begin
                irq_en_r <= reg_wdata[UMS_IRQ_W-1:0];
            end
        end
    end

    // ************************************************************
    // Modem change flags
    // ************************************************************
    // Set wins over a write-1 clear in the same cycle so no edge is lost.
    logic [3:0] chg_set, chg_clr;
    assign chg_set[UMS_BIT_CTS_CHG] = pin_chg[0]; // [RULE_01]
    assign chg_set[UMS_BIT_DSR_CHG] = pin_chg[1]; // [RULE_02]
    assign chg_set[UMS_BIT_RING_TRAIL] = pin_chg[2] & s3_r[2]; // [RULE_03]
    assign chg_set[UMS_BIT_CD_CHG] = pin_chg[3]; // [RULE_04]
    assign chg_clr = (reg_wr && hit_status) ? reg_wdata[3:0] : 4'h0;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            chg_r <= 4'h0;
        end else begin
            chg_r <= (chg_r & ~chg_clr) | chg_set; // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
        end
    end

    logic loop_on;
    logic [3:0] level_bits;
    assign loop_on = ctl_r[UMS_CTL_LOOP];
    assign level_bits = loop_on ?
        {ctl_r[UMS_CTL_CD], ctl_r[UMS_CTL_RING], ctl_r[UMS_CTL_RTS], ctl_r[UMS_CTL_DTR]} : // [RULE_05] [RULE_06] [RULE_07] [RULE_08]
        ~stable_r; // [RULE_09]

    logic [7:0] status_val;
    assign status_val = {level_bits, chg_r};

    // ************************************************************
    // Baud generation
    // ************************************************************
    // 96 MHz / 6.5 is done as a fractional accumulator on the master tick.
    logic [4:0] frac_r;
    logic [4:0] frac_sum;
    logic baud_clk_en;
    assign frac_sum = frac_r + UMS_FRAC_NUM;
    assign baud_clk_en = master_clk_tick && (frac_sum >= UMS_FRAC_DEN); // [RULE_11]

    logic [15:0] divisor, div_cnt_r;
    logic [3:0] ovs_r;
    assign divisor = {div_high_r, div_low_r}; // [RULE_10]
    logic div_done;
    assign div_done = baud_clk_en && (div_cnt_r <= UMS_DIV_ONE);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            frac_r <= 5'h00;
            div_cnt_r <= 16'h0000;
            ovs_r <= 4'h0;
            baud_x16_tick <= 1'b0;
            bit_tick <= 1'b0;
        end else begin
            if (master_clk_tick) begin
                frac_r <= baud_clk_en ? (frac_sum - UMS_FRAC_DEN) : frac_sum; // [RULE_11]
            end
            if (div_done) begin
                div_cnt_r <= divisor; // [RULE_12]
                ovs_r <= ovs_r + 4'h1;
            end else if (baud_clk_en) begin
                div_cnt_r <= div_cnt_r - UMS_DIV_ONE;
            end
            baud_x16_tick <= div_done;
            bit_tick <= div_done && (ovs_r == UMS_OVS_LAST); // [RULE_12]
        end
    end

    // ************************************************************
    // Xon/Xoff matching and interrupts
    // ************************************************************
    logic xon_hit, xoff_hit;
    assign xon_hit = rx_byte.valid && (rx_byte.data == xon_r); // [RULE_13]
    assign xoff_hit = rx_byte.valid && (rx_byte.data == xoff_r); // [RULE_14]
    assign resume_char = xon_r; // [RULE_15]
    assign pause_char = xoff_r; // [RULE_16]

    logic [UMS_IRQ_W-1:0] ev_set, ev_clr;
    assign ev_set[UMS_IRQ_MODEM] = |chg_set;
    assign ev_set[UMS_IRQ_RESUME] = xon_hit;
    assign ev_set[UMS_IRQ_PAUSE] = xoff_hit;
    assign ev_clr = (reg_wr && hit_icl) ? reg_wdata[UMS_IRQ_W-1:0] : '0;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            dma_paused <= 1'b0;
            irq_st_r <= '0;
        end else begin
            if (xoff_hit) begin
                dma_paused <= 1'b1; // [RULE_14]
            end else if (xon_hit) begin
                dma_paused <= 1'b0; // [RULE_18]
            end
            irq_st_r <= (irq_st_r & ~ev_clr) | ev_set;
        end
    end

    // Modem request is a level from the live change flags, so clearing them drops it.
    logic modem_req;
    assign modem_req = (|chg_r) & irq_en_r[UMS_IRQ_MODEM]; // [RULE_19]
    assign irq = modem_req | (|(irq_st_r & irq_en_r & ~(UMS_IRQ_W'(1) << UMS_IRQ_MODEM))); // [RULE_13] [RULE_14]

    // ************************************************************
    // Read path
    // ************************************************************
    logic [7:0] rd_mux;
    assign rd_mux = hit_status ? status_val :
                    hit_div_lo ? div_low_r :
                    hit_div_hi ? div_high_r :
                    hit_xon ? xon_r :
                    hit_xoff ? xoff_r :
                    hit_ctl ? ctl_r :
                    hit_ist ? {5'h00, irq_st_r} :
                    hit_ien ? {5'h00, irq_en_r} : UMS_BYTE_ZERO;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            reg_rdata <= UMS_BYTE_ZERO;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : UMS_BYTE_ZERO;
        end
    end
endmodule : ums_core
`default_nettype wire

// [shared/ums_pkg.sv]
// Package for the modem status, baud divisor and flow character block.
`default_nettype none
package ums_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [15:0] UMS_ADDR_MODEM_LINE_STATUS = 16'hffa6;
    localparam logic [15:0] UMS_ADDR_BAUD_DIVISOR_LOW = 16'hffa7;
    localparam logic [15:0] UMS_ADDR_BAUD_DIVISOR_HIGH = 16'hffa8;
    localparam logic [15:0] UMS_ADDR_RESUME_CHAR_MATCH = 16'hffa9;
    localparam logic [15:0] UMS_ADDR_PAUSE_CHAR_MATCH = 16'hffaa;
    localparam logic [15:0] UMS_ADDR_MODEM_LINE_CONTROL = 16'hffb0;
    localparam logic [15:0] UMS_ADDR_IRQ_STATUS = 16'hffb1;
    localparam logic [15:0] UMS_ADDR_IRQ_CLEAR = 16'hffb2;
    localparam logic [15:0] UMS_ADDR_IRQ_ENABLE = 16'hffb3;

    // ************************************************************
    // Reset values and fields
    // ************************************************************
    localparam logic [7:0] UMS_DIV_LOW_RST = 8'h08;
    localparam logic [7:0] UMS_DIV_HIGH_RST = 8'h00;
    localparam logic [7:0] UMS_CHAR_RST = 8'h00;
    localparam logic [7:0] UMS_BYTE_ZERO = 8'h00;
    localparam int UMS_BIT_CTS_CHG = 0;
    localparam int UMS_BIT_DSR_CHG = 1;
    localparam int UMS_BIT_RING_TRAIL = 2;
    localparam int UMS_BIT_CD_CHG = 3;
    localparam int UMS_CTL_DTR = 4;
    localparam int UMS_CTL_RTS = 5;
    localparam int UMS_CTL_RING = 6;
    localparam int UMS_CTL_CD = 7;
    localparam int UMS_CTL_LOOP = 0;
    // Interrupt status bits.
    localparam int UMS_IRQ_MODEM = 0;
    localparam int UMS_IRQ_RESUME = 1;
    localparam int UMS_IRQ_PAUSE = 2;
    localparam int UMS_IRQ_W = 3;

    // ************************************************************
    // Baud clock: 96 MHz / 6.5 = 192 MHz / 13, two clock edges per step.
    // ************************************************************
    localparam int UMS_MASTER_DIV_NUM = 2;
    localparam int UMS_MASTER_DIV_DEN = 13;
    localparam logic [4:0] UMS_FRAC_NUM = 5'(UMS_MASTER_DIV_NUM);
    localparam logic [4:0] UMS_FRAC_DEN = 5'(UMS_MASTER_DIV_DEN);
    localparam int UMS_OVERSAMPLE = 16;
    localparam logic [3:0] UMS_OVS_LAST = 4'(UMS_OVERSAMPLE - 1);
    localparam logic [15:0] UMS_DIV_ONE = 16'h0001;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } ums_rx_byte_t;

    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic ring_n;
        logic cd_n;
    } ums_modem_in_t;
endpackage : ums_pkg
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the modem status, divisor and flow character core.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import ums_pkg::*;
    localparam logic [15:0] ST = UMS_ADDR_MODEM_LINE_STATUS;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic master_clk_tick = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic [3:0] want_low = 4'h0;
    ums_rx_byte_t rx_byte = '0;
    ums_modem_in_t modem_in;
    logic [7:0] reg_rdata, resume_char, pause_char, a;
    logic dma_paused, baud_x16_tick, bit_tick, irq;
    logic [15:0] exq[$];
    logic [15:0] q;
    logic [15:0] dv[3] = '{16'h0008, 16'h0001, 16'h0102};
    int bad_count = 0;
    int checked = 0;
    int n;
    always #10 sys_clk = ~sys_clk;
    ums_modem_model i_modem (.want_low, .pins(modem_in));
    ums_core i_dut (.sys_clk, .master_clk_tick, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .modem_in, .rx_byte, .resume_char, .pause_char, .dma_paused, .baud_x16_tick, .bit_tick, .irq);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up;
        $display("Counts: %0d compared, %0d mismatched", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    // Strobes drop for one idle cycle, so no signal is driven twice in a step.
    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [15:0] ad, input logic [7:0] x, input logic [7:0] m);
        exq.push_back({m, x});
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
    endtask : rd
    task automatic rx(input logic [7:0] d);
        rx_byte <= '{data: d, valid: 1'b1};
        @(posedge sys_clk);
        rx_byte.valid <= 1'b0;
        @(posedge sys_clk);
    endtask : rx
    task automatic wait_tick;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (bit_tick !== 1'b1 && n < 40000);
        if (n >= 40000) begin
            bad_count++;
            wrap_up;
        end
    endtask : wait_tick
    always @(posedge sys_clk) begin
        rd_d <= reg_rd;
        if (rd_d) begin
            q = exq.pop_front();
            chk(reg_rdata & q[15:8], q[7:0] & q[15:8]);
        end
    end
    initial begin
        void'($urandom(32'h6037));
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        rd(UMS_ADDR_BAUD_DIVISOR_LOW, 8'h08, 8'hff);
        rd(UMS_ADDR_BAUD_DIVISOR_HIGH, 8'h00, 8'hff);
        rd(UMS_ADDR_PAUSE_CHAR_MATCH, 8'h00, 8'hff);
        rd(UMS_ADDR_RESUME_CHAR_MATCH, 8'h00, 8'hff);
        rd(16'hffa5, 8'h00, 8'hff);
        $display("Reset values done");
        for (int k = 0; k < 3; k++) begin
            wr(UMS_ADDR_BAUD_DIVISOR_LOW, dv[k][7:0]);
            wr(UMS_ADDR_BAUD_DIVISOR_HIGH, dv[k][15:8]);
            wait_tick;
            wait_tick;
            chk(16'(n), dv[k] * 16'd104);
        end
        $display("Baud timing done");
        wr(UMS_ADDR_IRQ_ENABLE, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(ST, 8'h0f);
            want_low[i] <= 1'b1;
            repeat (8) @(posedge sys_clk);
            wr(ST, 8'h00);
            rd(ST, {want_low, i == 2 ? 4'h0 : 4'h1 << i}, 8'hff);
            chk(16'(irq), 16'(i != 2));
            want_low[i] <= 1'b0;
            repeat (8) @(posedge sys_clk);
            rd(ST, 8'h01 << i, 8'hff);
            wr(ST, 8'h01 << i);
            rd(ST, 8'h00, 8'hff);
            chk(16'(irq), 16'h0000);
        end
        for (int i = 0; i < 4; i++) begin
            a = 8'($urandom) | 8'h01;
            wr(UMS_ADDR_MODEM_LINE_CONTROL, a);
            rd(ST, a, 8'hf0);
        end
        wr(UMS_ADDR_MODEM_LINE_CONTROL, 8'h00);
        $display("Modem status done");
        a = 8'($urandom);
        wr(UMS_ADDR_RESUME_CHAR_MATCH, a);
        wr(UMS_ADDR_PAUSE_CHAR_MATCH, ~a);
        rd(UMS_ADDR_RESUME_CHAR_MATCH, a, 8'hff);
        chk({resume_char, pause_char}, {a, ~a});
        wr(UMS_ADDR_IRQ_CLEAR, 8'h07);
        wr(UMS_ADDR_IRQ_ENABLE, 8'h06);
        rx(~a);
        chk({dma_paused, irq}, 16'h0003);
        rx(a ^ 8'h01);
        chk(16'(dma_paused), 16'h0001);
        rx(a);
        chk(16'(dma_paused), 16'h0000);
        rd(UMS_ADDR_IRQ_STATUS, 8'h06, 8'h06);
        wr(UMS_ADDR_IRQ_CLEAR, 8'h06);
        wr(UMS_ADDR_IRQ_ENABLE, 8'h00);
        rx(~a);
        chk({dma_paused, irq}, 16'h0002);
        $display("Flow characters done");
        wrap_up;
    end
endmodule : tb
`default_nettype wire

// [verif/ums_core_assertions.sv]
// Port checker for the modem status, divisor and flow character core.
`timescale 1ns/1ns
`default_nettype none
module ums_core_checker
    import ums_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire ums_rx_byte_t rx_byte,
    input wire logic [7:0] resume_char,
    input wire logic [7:0] pause_char,
    input wire logic dma_paused,
    input wire logic bit_tick,
    input wire logic baud_x16_tick,
    input wire logic irq
);
    logic [7:0] ctl_r;
    wire w_on = reg_wr && reg_addr == UMS_ADDR_RESUME_CHAR_MATCH;
    wire w_off = reg_wr && reg_addr == UMS_ADDR_PAUSE_CHAR_MATCH;
    wire r_on = reg_rd && reg_addr == UMS_ADDR_RESUME_CHAR_MATCH;
    wire r_st = reg_rd && reg_addr == UMS_ADDR_MODEM_LINE_STATUS;
    wire w_en0 = reg_wr && reg_addr == UMS_ADDR_IRQ_ENABLE && reg_wdata == 8'h00;
    wire m_off = rx_byte.valid && rx_byte.data == pause_char;
    wire m_on = rx_byte.valid && rx_byte.data == resume_char && !m_off;
    // Shadow of the control register, so loopback reads can be judged.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctl_r <= 8'h00;
        end else if (reg_wr && reg_addr == UMS_ADDR_MODEM_LINE_CONTROL) begin
            ctl_r <= reg_wdata;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ************************************************************
    // Assertions
    // ************************************************************
    resume_wr_a: assert property (w_on |=> resume_char == $past(reg_wdata))
        else $error("resume byte not updated");
    pause_wr_a: assert property (w_off |=> pause_char == $past(reg_wdata))
        else $error("pause byte not updated");
    resume_rd_a: assert property (r_on |=> reg_rdata == $past(resume_char))
        else $error("resume byte read back wrong");
    pause_set_a: assert property (m_off |=> dma_paused)
        else $error("pause match did not pause");
    pause_clr_a: assert property (m_on ##1 !m_off |-> !dma_paused)
        else $error("resume match did not resume");
    loop_show_a: assert property (r_st && ctl_r[0] |=> reg_rdata[7:4] == $past(ctl_r[7:4]))
        else $error("loopback status wrong");
    irq_off_a: assert property (w_en0 |=> !irq [*3])
        else $error("irq with all sources disabled");
    tick_one_a: assert property ($rose(bit_tick) |=> !bit_tick ##1 !bit_tick)
        else $error("bit tick too long or too close");
    tick_pair_a: assert property (bit_tick |-> baud_x16_tick)
        else $error("bit tick without baud tick");
    cover property (m_off ##1 dma_paused);
    cover property (m_on ##1 !dma_paused);
    cover property (r_st && ctl_r[0]);
endmodule : ums_core_checker
bind ums_core ums_core_checker i_chk (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rx_byte, .resume_char, .pause_char, .dma_paused, .bit_tick, .baud_x16_tick, .irq);
`default_nettype wire

// [verif/ums_modem_model.sv]
// Modem-side model that drives the active-low control pins.
`timescale 1ns/1ns
`default_nettype none
module ums_modem_model
    import ums_pkg::*;
(
    input wire logic [3:0] want_low,
    output ums_modem_in_t pins
);
    // Pins move 7 ns after a request, so they are never aligned to the clock edge.
    assign #7 pins = {~want_low[0], ~want_low[1], ~want_low[2], ~want_low[3]};
endmodule : ums_modem_model
`default_nettype wire
